// ### sim/pcg_pll_model.sv
// behavioural analog pll and oscillator seen by the control block
`default_nettype none
module pcg_pll_model
#(
    parameter int SETTLE = 12
)
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic lock_req,
    input  wire logic crystal_run,
    output logic      crystal_tick,
    output logic      vco_tick,
    output logic      vco_lock_in,
    output logic      vco_track_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import pcg_pkg::*;
    logic [2:0] xdiv_reg;
    int         settle_reg;

    // vco at half the system rate, crystal at one eighth; a stopped crystal gives no ticks at all
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            vco_tick     <= 1'b0;
            crystal_tick <= 1'b0;
            xdiv_reg     <= 3'h0;
        end
        else
        begin
            vco_tick     <= ~vco_tick;
            xdiv_reg     <= xdiv_reg + 3'h1;
            crystal_tick <= crystal_run && (xdiv_reg == 3'h0);
        end
    end

    // lock follows the request only after settling; tracking is reached halfway
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            vco_lock_in  <= 1'b0;
            vco_track_in <= 1'b0;
            settle_reg   <= 0;
        end
        else if (lock_req != vco_lock_in)
        begin
            settle_reg <= settle_reg + 1;
            if (settle_reg == SETTLE / 2)
                vco_track_in <= lock_req;
            if (settle_reg == SETTLE)
                vco_lock_in <= lock_req;
        end
        else
            settle_reg <= 0;
    end
endmodule
`default_nettype wire

// ### sim/pll_clock_generator_control_bench.sv
// self-checking bench of the pll clock generator control block
`default_nettype none
module pll_clock_generator_control_bench import pcg_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic       ref_clk, sys_rst, reg_wr, reg_rd, osc_enable_from_sim, break_state;
    logic       break_clear_flag_enable, lock_req, crystal_run;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       crystal_tick, vco_tick, vco_lock_in, vco_track_in;
    logic       crystal_clock, base_clock_out, pll_interrupt_line, pll_enable_out, track_mode_out, feedback_pulse;
    logic [3:0] vco_range_out;
    int         err_count, compares, cycles, seed;
    logic [3:0] mul_tab [4];

    pcg_top i_pcg_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .crystal_tick(crystal_tick),
        .vco_tick(vco_tick), .vco_lock_in(vco_lock_in), .vco_track_in(vco_track_in),
        .osc_enable_from_sim(osc_enable_from_sim), .break_state(break_state),
        .break_clear_flag_enable(break_clear_flag_enable), .crystal_clock(crystal_clock),
        .base_clock_out(base_clock_out), .pll_interrupt_line(pll_interrupt_line),
        .pll_enable_out(pll_enable_out), .track_mode_out(track_mode_out), .vco_range_out(vco_range_out),
        .feedback_pulse(feedback_pulse));

    pcg_pll_model i_pcg_pll_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .lock_req(lock_req),
        .crystal_run(crystal_run), .crystal_tick(crystal_tick), .vco_tick(vco_tick),
        .vco_lock_in(vco_lock_in), .vco_track_in(vco_track_in));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_of_test();
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask

    // expected feedback divide ratio for a multiplier field
    function automatic logic [7:0] n_of(input logic [3:0] m);
        return (m == FIELD_ZERO) ? {4'h0, MUL_ZERO_AS} : {4'h0, m};
    endfunction

    // vco ticks counted from one feedback pulse up to the next
    task automatic period_chk(input logic [3:0] m);
        int cnt;
        int guard;
        cnt   = 0;
        guard = 0;
        cyc(1);
        while (feedback_pulse !== 1'b1 && guard < 200)
        begin
            cyc(1);
            guard++;
        end
        do
        begin
            if (vco_tick === 1'b1)
                cnt++;
            cyc(1);
            guard++;
        end while (feedback_pulse !== 1'b1 && guard < 400);
        check(cnt[7:0], n_of(m));
    endtask

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end

    initial
    begin
        err_count = 0;
        compares = 0;
        cycles = 0;
        seed = 32'hc52f_3bc8;
        sys_rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        osc_enable_from_sim = 1'b1;
        break_state = 1'b0;
        break_clear_flag_enable = 1'b0;
        lock_req = 1'b0;
        crystal_run = 1'b1;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_chk(PROG_ADDR, 8'h66);
        rd_chk(CTL_ADDR, 8'h2f);
        rd_chk(BW_ADDR, 8'h00);
        rd_chk(8'h1f, 8'h00);
        check({7'h0, pll_enable_out}, 8'h01);
        // select the vco while unlocked, then probe crystal loss with the crystal stopped and running
        wr(CTL_ADDR, 8'h30);
        rd_chk(CTL_ADDR, 8'h3f);
        crystal_run <= 1'b0;
        wr(BW_ADDR, 8'h10);
        cyc(4);
        rd_chk(BW_ADDR, 8'h10);
        crystal_run <= 1'b1;
        wr(BW_ADDR, 8'h10);
        cyc(60);
        rd_chk(BW_ADDR, 8'h00);
        wr(CTL_ADDR, 8'h10);
        rd_chk(CTL_ADDR, 8'h3f);
        // stop mode drops every clock output and deselects the vco
        @(posedge ref_clk);
        osc_enable_from_sim <= 1'b0;
        cyc(2);
        repeat (4)
        begin
            check({5'h0, crystal_clock, base_clock_out, pll_interrupt_line}, 8'h00);
            cyc(1);
        end
        osc_enable_from_sim <= 1'b1;
        rd_chk(CTL_ADDR, 8'h2f);
        wr(BW_ADDR, 8'h10);
        rd_chk(BW_ADDR, 8'h00);
        // programming register only moves while the pll is off
        wr(PROG_ADDR, 8'h12);
        rd_chk(PROG_ADDR, 8'h66);
        wr(CTL_ADDR, 8'h00);
        wr(CTL_ADDR, 8'h10);
        rd_chk(CTL_ADDR, 8'h0f);
        mul_tab = '{4'h0, 4'h1, 4'hf, 4'h2};
        mul_tab[3] = 4'(2 + (($random(seed) & 32'h7fff_ffff) % 13));
        foreach (mul_tab[i])
        begin
            wr(PROG_ADDR, {mul_tab[i], 4'h6});
            rd_chk(PROG_ADDR, {mul_tab[i], 4'h6});
            wr(CTL_ADDR, 8'h20);
            period_chk(mul_tab[i]);
            wr(CTL_ADDR, 8'h00);
        end
        wr(PROG_ADDR, 8'h50);
        wr(CTL_ADDR, 8'h20);
        wr(CTL_ADDR, 8'h30);
        cyc(3);
        check({3'h0, pll_enable_out, vco_range_out}, 8'h00);
        rd_chk(CTL_ADDR, 8'h2f);
        wr(CTL_ADDR, 8'h00);
        wr(PROG_ADDR, 8'h66);
        wr(CTL_ADDR, 8'h20);
        // automatic bandwidth: lock changes raise the flag, a read clears it
        lock_req <= 1'b1;
        cyc(20);
        wr(BW_ADDR, 8'h80);
        cyc(4);
        check({7'h0, pll_interrupt_line}, 8'h00);
        rd_chk(CTL_ADDR, 8'h6f);
        rd_chk(BW_ADDR, 8'he0);
        check({7'h0, track_mode_out}, 8'h01);
        rd_chk(CTL_ADDR, 8'h2f);
        // lock was confirmed just above; the vco select needs no lock and is set again here
        wr(CTL_ADDR, 8'h30);
        rd_chk(CTL_ADDR, 8'h3f);
        wr(CTL_ADDR, 8'ha0);
        lock_req <= 1'b0;
        cyc(20);
        check({7'h0, pll_interrupt_line}, 8'h01);
        rd_chk(BW_ADDR, 8'h80);
        rd_chk(CTL_ADDR, 8'hef);
        cyc(3);
        check({7'h0, pll_interrupt_line}, 8'h00);
        // break state protects the flag unless clearing is enabled
        lock_req <= 1'b1;
        cyc(20);
        break_state <= 1'b1;
        rd_chk(CTL_ADDR, 8'hef);
        rd_chk(CTL_ADDR, 8'hef);
        break_clear_flag_enable <= 1'b1;
        rd_chk(CTL_ADDR, 8'hef);
        break_state <= 1'b0;
        break_clear_flag_enable <= 1'b0;
        rd_chk(CTL_ADDR, 8'haf);
        // leaving auto mode hides the flag and the enable
        lock_req <= 1'b0;
        cyc(20);
        wr(BW_ADDR, 8'h00);
        rd_chk(CTL_ADDR, 8'h2f);
        check({7'h0, pll_interrupt_line}, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire

// ### verilog/pcg_fb_divider.sv
// modulo feedback divider of the vco clock
`default_nettype none
module pcg_fb_divider
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic       vco_tick,
    input  wire logic [3:0] mul_field,
    output logic      [3:0] n_value,
    output logic            fb_pulse
);
    import pcg_pkg::*;

    logic [3:0] count_reg;

    // a zero field divides like one
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            n_value <= MUL_RESET;
        else
            n_value <= (mul_field == FIELD_ZERO) ? MUL_ZERO_AS : mul_field;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !run)
        begin
            count_reg <= FIELD_ZERO;
            fb_pulse  <= 1'b0;
        end
        else if (vco_tick)
        begin
            if (count_reg >= n_value - 4'h1)
            begin
                count_reg <= FIELD_ZERO;
                fb_pulse  <= 1'b1;
            end
            else
            begin
                count_reg <= count_reg + 4'h1;
                fb_pulse  <= 1'b0;
            end
        end
        else
            fb_pulse <= 1'b0;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    mul_n_a: assert property ((mul_field != FIELD_ZERO) |=> n_value == $past(mul_field))
        else $error("multiplier n does not follow the field");
endmodule
`default_nettype wire

// ### verilog/pcg_pkg.sv
// constants for the pll clock generator control block
`default_nettype none
package pcg_pkg;
    // register addresses on the plain register port
    localparam logic [7:0] CTL_ADDR        = 8'h1c;
    localparam logic [7:0] BW_ADDR         = 8'h1d;
    localparam logic [7:0] PROG_ADDR       = 8'h1e;
    // control register fields
    localparam int         CTL_IE_BIT      = 7;
    localparam int         CTL_FLAG_BIT    = 6;
    localparam int         CTL_ON_BIT      = 5;
    localparam int         CTL_SEL_BIT     = 4;
    localparam logic [3:0] CTL_LOW_ONES    = 4'hf;
    // bandwidth register fields
    localparam int         BW_AUTO_BIT     = 7;
    localparam int         BW_LOCK_BIT     = 6;
    localparam int         BW_TRACK_BIT    = 5;
    localparam int         BW_LOSS_BIT     = 4;
    localparam logic [3:0] BW_LOW_ZEROS    = 4'h0;
    // programming register fields and reset values
    localparam int         MUL_MSB         = 7;
    localparam int         MUL_LSB         = 4;
    localparam int         RANGE_MSB       = 3;
    localparam int         RANGE_LSB       = 0;
    localparam logic [3:0] MUL_RESET       = 4'h6;
    localparam logic [3:0] RANGE_RESET     = 4'h6;
    localparam logic [3:0] FIELD_ZERO      = 4'h0;
    localparam logic [3:0] MUL_ZERO_AS     = 4'h1;
    localparam logic       IE_RESET        = 1'b0;
    localparam logic       ON_RESET        = 1'b1;
    localparam logic       SEL_RESET       = 1'b0;
    // crystal loss check lasts n vco cycles shifted left by this
    localparam int         LOSS_WAIT_SHIFT = 2;
    typedef enum logic [1:0] {
        LOSS_IDLE  = 2'b01,
        LOSS_CHECK = 2'b10
    } pcg_chk_state_type;
endpackage
`default_nettype wire

// ### verilog/pcg_top.sv
// pll clock generator control: registers, lock flag, base clock select
//
// Decided for this implementation: the address-and-strobe port.
`default_nettype none
module pcg_top
(
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       crystal_tick,
    input  wire logic       vco_tick,
    input  wire logic       vco_lock_in,
    input  wire logic       vco_track_in,
    input  wire logic       osc_enable_from_sim,
    input  wire logic       break_state,
    input  wire logic       break_clear_flag_enable,
    output logic            crystal_clock,
    output logic            base_clock_out,
    output logic            pll_interrupt_line,
    output logic            pll_enable_out,
    output logic            track_mode_out,
    output logic      [3:0] vco_range_out,
    output logic            feedback_pulse
);
    import pcg_pkg::*;

    logic              pll_irq_enable;
    logic              pll_irq_flag;
    logic              pll_enable_bit;
    logic              base_clock_select;
    logic              auto_reg;
    logic              lock_reg;
    logic              track_manual_reg;
    logic              track_reg;
    logic              crystal_loss_detect;
    logic [3:0]        vco_multiplier_field;
    logic [3:0]        vco_range_field;
    logic [3:0]        n_value;
    logic [5:0]        loss_count_reg;
    logic [5:0]        loss_limit;
    pcg_chk_state_type loss_state_reg;
    logic              wr_ctl;
    logic              wr_bw;
    logic              wr_prog;
    logic              rd_ctl;
    logic              range_zero;
    logic              lock_sample;
    logic              lock_change;
    logic              flag_clear;
    logic [7:0]        ctl_view;
    logic [7:0]        bw_view;

    assign wr_ctl      = reg_wr && (reg_addr == CTL_ADDR);
    assign wr_bw       = reg_wr && (reg_addr == BW_ADDR);
    assign wr_prog     = reg_wr && (reg_addr == PROG_ADDR);
    assign rd_ctl      = reg_rd && (reg_addr == CTL_ADDR);
    assign range_zero  = (vco_range_field == FIELD_ZERO);
    assign lock_sample = auto_reg && pll_enable_out && vco_lock_in;
    assign lock_change = auto_reg && (lock_sample != lock_reg);
    // break state shields the flag unless the break unit allows clearing
    assign flag_clear  = rd_ctl && (!break_state || break_clear_flag_enable);
    // n is at most fifteen, so four times n still fits six bits
    assign loss_limit  = 6'(n_value) << LOSS_WAIT_SHIFT;

    // wait mode has no input here: the block simply keeps running as in run mode

    // control register: enable and select guard each other
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pll_enable_bit    <= ON_RESET;
            base_clock_select <= SEL_RESET;
        end
        else
        begin
            if (wr_ctl)
                pll_enable_bit <= reg_wdata[CTL_ON_BIT] | base_clock_select;
            if (!osc_enable_from_sim || range_zero)
                base_clock_select <= 1'b0;
            else if (wr_ctl)
                base_clock_select <= reg_wdata[CTL_SEL_BIT] & pll_enable_bit;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pll_irq_enable <= IE_RESET;
        else if (!auto_reg)
            pll_irq_enable <= 1'b0;
        else if (wr_ctl)
            pll_irq_enable <= reg_wdata[CTL_IE_BIT];
    end

    // a lock change in the same cycle as a clearing read wins
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pll_irq_flag <= 1'b0;
        else if (!auto_reg)
            pll_irq_flag <= 1'b0;
        else if (lock_change)
            pll_irq_flag <= 1'b1;
        else if (flag_clear)
            pll_irq_flag <= 1'b0;
    end

    // bandwidth register; low test bits are not stored
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            auto_reg         <= 1'b0;
            track_manual_reg <= 1'b0;
        end
        else if (wr_bw)
        begin
            auto_reg <= reg_wdata[BW_AUTO_BIT];
            if (!auto_reg)
                track_manual_reg <= reg_wdata[BW_TRACK_BIT];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            lock_reg  <= 1'b0;
            track_reg <= 1'b0;
        end
        else
        begin
            lock_reg  <= lock_sample;
            // manual value is kept aside and comes back when auto ends
            track_reg <= auto_reg ? (pll_enable_out && vco_track_in) : track_manual_reg;
        end
    end

    // programming register is frozen as a whole while the pll is on
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            vco_multiplier_field <= MUL_RESET;
            vco_range_field      <= RANGE_RESET;
        end
        else if (wr_prog && !pll_enable_bit)
        begin
            vco_multiplier_field <= reg_wdata[MUL_MSB:MUL_LSB];
            vco_range_field      <= reg_wdata[RANGE_MSB:RANGE_LSB];
        end
    end

    // crystal loss check: armed by writing one, cleared by any crystal edge
    // within four times n vco cycles
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !base_clock_select)
        begin
            loss_state_reg      <= LOSS_IDLE;
            crystal_loss_detect <= 1'b0;
            loss_count_reg      <= 6'h00;
        end
        else
        begin
            case (loss_state_reg)
                LOSS_IDLE:
                begin
                    if (wr_bw && reg_wdata[BW_LOSS_BIT])
                    begin
                        crystal_loss_detect <= 1'b1;
                        loss_count_reg      <= 6'h00;
                        loss_state_reg      <= LOSS_CHECK;
                    end
                end
                LOSS_CHECK:
                begin
                    // the bit stays set after the window if no crystal edge came
                    if (crystal_tick)
                        crystal_loss_detect <= 1'b0;
                    if (vco_tick)
                    begin
                        if (loss_count_reg >= loss_limit - 6'h01)
                            loss_state_reg <= LOSS_IDLE;
                        else
                            loss_count_reg <= loss_count_reg + 6'h01;
                    end
                end
                default:
                    loss_state_reg <= LOSS_IDLE;
            endcase
        end
    end

    // read views; unimplemented bits read as printed
    assign ctl_view = {pll_irq_enable, pll_irq_flag & auto_reg, pll_enable_bit,
                       base_clock_select, CTL_LOW_ONES};
    assign bw_view  = {auto_reg, lock_reg & auto_reg, track_reg,
                       crystal_loss_detect & base_clock_select, BW_LOW_ZEROS};

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !reg_rd)
            reg_rdata <= 8'h00;
        else
        begin
            case (reg_addr)
                CTL_ADDR:  reg_rdata <= ctl_view;
                BW_ADDR:   reg_rdata <= bw_view;
                PROG_ADDR: reg_rdata <= {vco_multiplier_field, vco_range_field};
                default:   reg_rdata <= 8'h00;
            endcase
        end
    end

    // clock outputs; low while the oscillator enable is low
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !osc_enable_from_sim)
        begin
            crystal_clock  <= 1'b0;
            base_clock_out <= 1'b0;
        end
        else
        begin
            crystal_clock <= crystal_tick;
            // selected source divided by two; no lock check here
            if (base_clock_select ? vco_tick : crystal_tick)
                base_clock_out <= ~base_clock_out;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pll_interrupt_line <= 1'b0;
            pll_enable_out     <= 1'b0;
            track_mode_out     <= 1'b0;
            vco_range_out      <= RANGE_RESET;
        end
        else
        begin
            pll_interrupt_line <= osc_enable_from_sim && auto_reg && pll_irq_enable && pll_irq_flag;
            pll_enable_out     <= osc_enable_from_sim && pll_enable_bit && !range_zero;
            track_mode_out     <= track_reg;
            vco_range_out      <= vco_range_field;
        end
    end

    pcg_fb_divider u_div
    (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .run       (pll_enable_out),
        .vco_tick  (vco_tick),
        .mul_field (vco_multiplier_field),
        .n_value   (n_value),
        .fb_pulse  (feedback_pulse)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // register side checks
    loss_zero_a: assert property ((reg_rd && reg_addr == BW_ADDR && !base_clock_select)
        |=> !reg_rdata[BW_LOSS_BIT])
        else $error("crystal loss bit visible without vco select");
    loss_arm_a: assert property ((wr_bw && reg_wdata[BW_LOSS_BIT] && base_clock_select
        && loss_state_reg == LOSS_IDLE) |=> crystal_loss_detect)
        else $error("crystal loss check did not arm");
    prog_reset_a: assert property ($past(sys_rst) |-> reg_rdata == 8'h00
        && vco_multiplier_field == MUL_RESET && vco_range_field == RANGE_RESET)
        else $error("programming register reset value wrong");
    prog_write_a: assert property ((wr_prog && !pll_enable_bit)
        |=> vco_multiplier_field == $past(reg_wdata[MUL_MSB:MUL_LSB]))
        else $error("multiplier write lost while pll off");
    prog_freeze_a: assert property ((wr_prog && pll_enable_bit)
        |=> $stable(vco_multiplier_field) && $stable(vco_range_field))
        else $error("programming register changed while pll on");
    range_zero_a: assert property (range_zero |=> !base_clock_select ##1 !pll_enable_out)
        else $error("zero range left select or pll enabled");
    flag_set_a: assert property (lock_change |=> pll_irq_flag)
        else $error("lock change did not set the flag");
    irq_manual_a: assert property ((!auto_reg && $past(!auto_reg)) |-> !pll_interrupt_line && !pll_irq_flag)
        else $error("interrupt or flag while in manual mode");
    ie_manual_a: assert property (!auto_reg |=> !pll_irq_enable)
        else $error("interrupt enable set in manual mode");
    brk_hold_a: assert property ((rd_ctl && break_state && !break_clear_flag_enable
        && pll_irq_flag && auto_reg) |=> pll_irq_flag)
        else $error("flag cleared during protected break");
    read_clear_a: assert property ((rd_ctl && !break_state && !lock_change && auto_reg) |=> !pll_irq_flag)
        else $error("control read did not clear the flag");
    // clock output checks; the stop check looks one cycle ahead so a quick wake cannot trip it
    stop_low_a: assert property (!osc_enable_from_sim
        |=> !base_clock_out && !base_clock_select && !pll_interrupt_line)
        else $error("outputs or select not cleared in stop");
    xtal_copy_a: assert property (osc_enable_from_sim |=> crystal_clock == $past(crystal_tick))
        else $error("crystal clock output does not follow its tick");
    // each tick of the selected source toggles the base clock once, giving half rate
    vco_toggle_a: assert property ((osc_enable_from_sim && base_clock_select && vco_tick)
        |=> $changed(base_clock_out))
        else $error("base clock did not toggle on a vco tick");
    xtal_toggle_a: assert property ((osc_enable_from_sim && !base_clock_select && crystal_tick)
        |=> $changed(base_clock_out))
        else $error("base clock did not toggle on a crystal tick");
    // select guards
    on_hold_a: assert property (base_clock_select |=> pll_enable_bit)
        else $error("pll enable cleared while select set");
    sel_guard_a: assert property ((wr_ctl && !pll_enable_bit) |=> !base_clock_select)
        else $error("select set while pll enable clear");
endmodule
`default_nettype wire
